// [hdl/ica_appender.sv]
// Overview of operation
// - on each trigger while idle, capture every input and output line level
// - the snapshot is one 32-bit word, fixed bits per line
// - a snapshot bit is 0 for a low line, 1 for a high line
// - a chunk type can only be enabled while chunk mode is on
// - turning chunk mode off disables all chunk types; a chunk tail already started still completes
// - select a type, set its enable, then it follows every image
// - checksum chunk appended to every image when its type is enabled
// - checksum covers image data and all chunks but itself
// - checksum chunk is always the final word of the frame
// - parameter set index chunk carries the set used for the frame
// - index chunk enables only while parameter sequencing is enabled
`timescale 1ns/1ps
`default_nettype none
module ica_appender
   import ica_pkg::*;
(
   // clock and reset
   input  wire logic                     clk_in,
   input  wire logic                     reset_in,
   // register port
   input  wire ica_bus_s                 bus_in,
   output logic      [31:0]              rdata_out,
   // acquisition control
   input  wire logic                     trigger_in,
   input  wire logic                     seq_enabled_in,
   input  wire logic [INDEX_W-1:0]       seq_index_in,
   output logic                          busy_out,
   // line levels from the pins
   input  wire logic [NUM_IN_LINES-1:0]  in_lines_in,
   input  wire logic [NUM_OUT_LINES-1:0] out_lines_in,
   // image stream in
   input  wire logic                     in_valid_in,
   input  wire ica_word_s                in_word_in,
   output logic                          in_ready_out,
   // framed stream out
   output logic                          out_valid_out,
   output ica_word_s                     out_word_out,
   input  wire logic                     out_ready_in
);
   // ==================================================================
   // state and helpers
   ica_state_s  q;
   ica_state_s  d;
   logic        can_load;
   logic [31:0] snap_now;
   logic [31:0] crc_word;
   logic [15:0] crc_next;
   logic        sel_allowed;
   logic        ctrl_wr;
   logic        en_wr;

   // next chunk state from the chunks still to send
   function automatic ica_state_e next_st(input logic [NUM_CHUNKS-1:0] rem);
      if (rem[SEL_LINES])
         return ST_LINES;
      else if (rem[SEL_INDEX])
         return ST_INDEX;
      else if (rem[SEL_CHECKSUM])
         return ST_CRC;
      else
         return ST_IDLE;
   endfunction

   // ==================================================================
   // snapshot layout from the synchronised lines
   always_comb begin
      snap_now = 32'h0000_0000;
      snap_now[IN_BASE +: NUM_IN_LINES]   = q.sync2[NUM_IN_LINES-1:0];
      snap_now[OUT_BASE +: NUM_OUT_LINES] =
         q.sync2[NUM_LINES-1:NUM_IN_LINES];
   end

   // word fed to the checksum; the checksum chunk itself is never fed
   always_comb begin
      case (q.st)
         ST_IMAGE: crc_word = in_word_in.data;
         ST_LINES: crc_word = q.snap;
         ST_INDEX: crc_word = {{(32-INDEX_W){1'b0}}, q.index};
         default:  crc_word = 32'h0000_0000;
      endcase
   end

   ica_crc16 u_crc (
      .crc_in  (q.crc),
      .data_in (crc_word),
      .crc_out (crc_next)
   );

   // output register may take a word when empty or being drained
   assign can_load     = !q.ov || out_ready_in;
   assign in_ready_out = (q.st == ST_IMAGE) && can_load;
   assign ctrl_wr      = bus_in.wr && (bus_in.addr == ADDR_CTRL);
   assign en_wr        = bus_in.wr && (bus_in.addr == ADDR_ENABLE);
   // index type also needs sequencing; code 3 selects nothing
   assign sel_allowed  = q.global_on && (q.sel != 2'h3) &&
                         ((q.sel != SEL_INDEX) || seq_enabled_in);

   // ==================================================================
   // next state
   always_comb begin
      d       = q;
      d.sync1 = {out_lines_in, in_lines_in};
      d.sync2 = q.sync1;
      d.rdata = 32'h0000_0000;
      if (q.ov && out_ready_in)
         d.ov = 1'b0;

      // register reads, answered in the next cycle
      if (bus_in.rd) begin
         case (bus_in.addr)
            ADDR_CTRL:   d.rdata[CTRL_GLOBAL_BIT] = q.global_on;
            ADDR_SELECT: d.rdata[1:0] = q.sel;
            ADDR_ENABLE: d.rdata[ENABLE_BIT] = (q.sel != 2'h3) && q.en[q.sel];
            ADDR_STATUS: begin
               d.rdata[NUM_CHUNKS-1:0]    = q.en;
               d.rdata[STATUS_BUSY_BIT]   = (q.st != ST_IDLE);
            end
            ADDR_LINES:  d.rdata = q.snap;
            ADDR_CRC:    d.rdata[15:0] = q.last_crc;
            default:     d.rdata = 32'h0000_0000;
         endcase
      end

      // register writes
      if (ctrl_wr) begin
         d.global_on = bus_in.wdata[CTRL_GLOBAL_BIT];
         if (!bus_in.wdata[CTRL_GLOBAL_BIT]) begin
            d.en = '0;
            // a chunk tail already started completes to keep framing
            if (q.st == ST_IDLE || q.st == ST_IMAGE)
               d.fmask = '0;
         end
      end
      if (bus_in.wr && bus_in.addr == ADDR_SELECT)
         d.sel = bus_in.wdata[1:0];
      if (en_wr && q.sel != 2'h3) begin
         if (!bus_in.wdata[ENABLE_BIT])
            d.en[q.sel] = 1'b0;
         else if (sel_allowed)
            d.en[q.sel] = 1'b1;
      end

      // framer
      case (q.st)
         ST_IDLE: begin
            if (trigger_in) begin
               d.snap  = snap_now;
               d.index = seq_index_in;
               d.fmask = d.en;
               d.crc   = CRC_INIT;
               d.st    = ST_IMAGE;
            end
         end
         ST_IMAGE: begin
            if (in_valid_in && can_load) begin
               d.ov      = 1'b1;
               d.ow.data = in_word_in.data;
               d.ow.last = in_word_in.last && (d.fmask == '0);
               d.crc     = crc_next;
               if (in_word_in.last)
                  d.st = next_st(d.fmask);
            end
         end
         ST_LINES: begin
            if (can_load) begin
               d.ov      = 1'b1;
               d.ow.data = q.snap;
               d.ow.last = (q.fmask[2:1] == 2'b00);
               d.crc     = crc_next;
               d.st      = next_st(q.fmask & 3'b110);
            end
         end
         ST_INDEX: begin
            if (can_load) begin
               d.ov      = 1'b1;
               d.ow.data = {{(32-INDEX_W){1'b0}}, q.index};
               d.ow.last = !q.fmask[SEL_CHECKSUM];
               d.crc     = crc_next;
               d.st      = next_st(q.fmask & 3'b100);
            end
         end
         ST_CRC: begin
            if (can_load) begin
               d.ov       = 1'b1;
               d.ow.data  = {16'h0000, q.crc};
               d.ow.last  = 1'b1;
               d.last_crc = q.crc;
               d.st       = ST_IDLE;
            end
         end
         default: d.st = ST_IDLE;
      endcase
   end

   // ==================================================================
   // state register; constants only under reset
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         q.st        <= ST_IDLE;
         q.global_on <= GLOBAL_RESET;
         q.sel       <= SEL_LINES;
         q.en        <= ENABLE_RESET;
         q.fmask     <= ENABLE_RESET;
         q.sync1     <= '0;
         q.sync2     <= '0;
         q.snap      <= 32'h0000_0000;
         q.index     <= '0;
         q.crc       <= CRC_INIT;
         q.last_crc  <= CRC_INIT;
         q.ov        <= 1'b0;
         q.ow        <= '0;
         q.rdata     <= 32'h0000_0000;
      end else begin
         q <= d;
      end
   end

   assign rdata_out     = q.rdata;
   assign out_valid_out = q.ov;
   assign out_word_out  = q.ow;
   assign busy_out      = (q.st != ST_IDLE);

   // ==================================================================
   // checks
   chk_snap_capture: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (q.st == ST_IDLE && trigger_in) |=> (q.snap == $past(snap_now)))
      else $error("snapshot not taken at trigger");

   chk_snap_unused: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (q.snap & ~SNAP_USED) == 32'h0000_0000)
      else $error("unassigned snapshot bit set");

   chk_snap_level: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (q.st == ST_IDLE && trigger_in) |=>
      (q.snap[IN_BASE] == $past(q.sync2[0], 1)) &&
      (q.snap[OUT_BASE] == $past(q.sync2[NUM_IN_LINES], 1)))
      else $error("snapshot bit does not match line level");

   chk_mode_gate: assert property (
      @(posedge clk_in) disable iff (reset_in)
      !q.global_on |-> (q.en == '0))
      else $error("chunk enabled while chunk mode off");

   chk_mode_off: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (ctrl_wr && !bus_in.wdata[CTRL_GLOBAL_BIT] && q.st == ST_IDLE)
      |=> (q.en == '0) && (q.fmask == '0))
      else $error("chunk mode off did not clear enables");

   chk_crc_value: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (q.st == ST_CRC && can_load) |=>
      q.ov && (q.ow.data[15:0] == $past(q.crc)))
      else $error("checksum chunk carries wrong value");

   chk_crc_last: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (q.st == ST_CRC && can_load) |=> q.ow.last ##1 (q.st != ST_CRC))
      else $error("checksum chunk not final word");

   chk_index_word: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (q.st == ST_INDEX && can_load) |=>
      (q.ow.data == {{(32-INDEX_W){1'b0}}, $past(q.index)}))
      else $error("index chunk carries wrong value");

   chk_index_seq: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (en_wr && q.sel == SEL_INDEX && !seq_enabled_in && !q.en[SEL_INDEX])
      |=> !q.en[SEL_INDEX])
      else $error("index chunk enabled without sequencing");

   chk_snap_hold: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (q.st != ST_IDLE) |=> $stable(q.snap))
      else $error("snapshot changed during frame");

   chk_chunk_order: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (q.st == ST_LINES && can_load && q.fmask[SEL_INDEX]) |=>
      (q.st == ST_INDEX) && !q.ow.last)
      else $error("index chunk does not follow line chunk");

   chk_crc_excl: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (q.st == ST_CRC) |=> $stable(q.crc))
      else $error("checksum fed with its own chunk");

   chk_crc_tail: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (q.st == ST_INDEX && can_load && q.fmask[SEL_CHECKSUM]) |=>
      (q.st == ST_CRC) && !q.ow.last)
      else $error("checksum chunk missing after index chunk");

   chk_crc_init: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (q.st == ST_IDLE && trigger_in) |=> (q.crc == CRC_INIT))
      else $error("checksum not cleared at trigger");
endmodule
`default_nettype wire

// [inc/ica_pkg.sv]
`default_nettype none
package ica_pkg;
   // ==================================================================
   // register map (byte addresses)
   localparam logic [7:0]  ADDR_CTRL    = 8'h00;
   localparam logic [7:0]  ADDR_SELECT  = 8'h04;
   localparam logic [7:0]  ADDR_ENABLE  = 8'h08;
   localparam logic [7:0]  ADDR_STATUS  = 8'h0c;
   localparam logic [7:0]  ADDR_LINES   = 8'h10;
   localparam logic [7:0]  ADDR_CRC     = 8'h14;
   // ==================================================================
   // field positions and reset values
   localparam int          CTRL_GLOBAL_BIT = 0;
   localparam int          ENABLE_BIT      = 0;
   localparam int          STATUS_BUSY_BIT = 8;
   localparam logic        GLOBAL_RESET    = 1'b0;
   localparam logic [2:0]  ENABLE_RESET    = 3'h0;
   // ==================================================================
   // chunk type selector codes, also bit index into the enable mask
   localparam logic [1:0]  SEL_LINES    = 2'h0;
   localparam logic [1:0]  SEL_INDEX    = 2'h1;
   localparam logic [1:0]  SEL_CHECKSUM = 2'h2;
   localparam int          NUM_CHUNKS   = 3;
   // ==================================================================
   // line snapshot layout
   localparam int          NUM_IN_LINES  = 2;
   localparam int          NUM_OUT_LINES = 4;
   localparam int          NUM_LINES     = NUM_IN_LINES + NUM_OUT_LINES;
   localparam int          IN_BASE       = 0;
   localparam int          OUT_BASE      = 8;
   localparam logic [31:0] SNAP_USED     = 32'h0000_0f03;
   // ==================================================================
   // checksum definition
   localparam logic [15:0] CRC_POLY  = 16'h1021;
   localparam logic [15:0] CRC_INIT  = 16'h0000;
   localparam int          INDEX_W   = 8;
   // ==================================================================
   // framer states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_IMAGE = 5'h02,
      ST_LINES = 5'h04,
      ST_INDEX = 5'h08,
      ST_CRC   = 5'h10
   } ica_state_e;
   // stream word
   typedef struct packed {
      logic [31:0] data;
      logic        last;
   } ica_word_s;
   // register port request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } ica_bus_s;
   // complete state of the appender
   typedef struct packed {
      ica_state_e             st;
      logic                   global_on;
      logic [1:0]             sel;
      logic [NUM_CHUNKS-1:0]  en;
      logic [NUM_CHUNKS-1:0]  fmask;
      logic [NUM_LINES-1:0]   sync1;
      logic [NUM_LINES-1:0]   sync2;
      logic [31:0]            snap;
      logic [INDEX_W-1:0]     index;
      logic [15:0]            crc;
      logic [15:0]            last_crc;
      logic                   ov;
      ica_word_s              ow;
      logic [31:0]            rdata;
   } ica_state_s;
endpackage
`default_nettype wire

// [hdl/ica_crc16.sv]
`timescale 1ns/1ps
`default_nettype none
module ica_crc16
   import ica_pkg::*;
(
   // running checksum and next word, msb first
   input  wire logic [15:0] crc_in,
   input  wire logic [31:0] data_in,
   // checksum after the word
   output logic      [15:0] crc_out
);
   // ==================================================================
   // one shift stage per data bit, no reflection
   logic [15:0] stage [0:32];
   assign stage[0] = crc_in;
   genvar i;
   for (i = 0; i < 32; i++) begin : g_bit
      logic fb;
      assign fb = stage[i][15] ^ data_in[31-i];
      assign stage[i+1] = {stage[i][14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
   end
   assign crc_out = stage[32];
endmodule
`default_nettype wire

// [test/ica_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ===================================================================
// host side parser: recomputes the checksum of every received frame
module ica_host_model
   import ica_pkg::*;
(
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   // framed stream from the appender
   input  wire logic        valid_in,
   input  wire ica_word_s   word_in,
   input  wire logic        stall_in,
   output logic             ready_out,
   // parsed frame
   output logic             done_out,
   output logic             crc_ok_out,
   output logic [3:0]       count_out,
   output logic [31:0]      words_out [8]
);
   logic [15:0] crc_q;
   logic [3:0]  n_q;
   logic        tog_q;
   // x-modem crc over one word, msb first, no reflection
   function automatic logic [15:0] crc_word(input logic [15:0] c,
                                            input logic [31:0] d);
      for (int i = 31; i >= 0; i--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
      end
      return c;
   endfunction
   // half-rate ready when stalling, so words must wait and hold
   assign ready_out = !stall_in | tog_q;
   // last word is judged against the crc of all words before it
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         crc_q      <= 16'h0000;
         n_q        <= 4'h0;
         tog_q      <= 1'b0;
         done_out   <= 1'b0;
         crc_ok_out <= 1'b0;
         count_out  <= 4'h0;
      end else begin
         tog_q    <= ~tog_q;
         done_out <= 1'b0;
         if (valid_in && ready_out) begin
            words_out[n_q[2:0]] <= word_in.data;
            if (word_in.last) begin
               done_out   <= 1'b1;
               count_out  <= n_q + 4'h1;
               crc_ok_out <= (word_in.data === {16'h0000, crc_q});
               n_q        <= 4'h0;
               crc_q      <= 16'h0000;
            end else begin
               n_q   <= n_q + 4'h1;
               crc_q <= crc_word(crc_q, word_in.data);
            end
         end
      end
   end
endmodule
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb
   import ica_pkg::*;
;
   logic clk_in, reset_in, trigger_in, seq_enabled_in, stall;
   logic in_valid_in, in_ready_out, out_valid_out, out_ready_in, busy_out;
   logic done, crc_ok;
   logic [3:0]  count, out_lines_in;
   logic [1:0]  in_lines_in;
   logic [7:0]  seq_index_in;
   logic [31:0] rdata_out, rd;
   logic [31:0] words [8];
   ica_bus_s    bus_in;
   ica_word_s   in_word_in, out_word_out;
   int          mismatches, samples_checked;
   // ================================================================
   // design and host parser
   ica_appender u_dut (.clk_in(clk_in), .reset_in(reset_in),
      .bus_in(bus_in), .rdata_out(rdata_out), .trigger_in(trigger_in),
      .seq_enabled_in(seq_enabled_in), .seq_index_in(seq_index_in),
      .busy_out(busy_out), .in_lines_in(in_lines_in),
      .out_lines_in(out_lines_in), .in_valid_in(in_valid_in),
      .in_word_in(in_word_in), .in_ready_out(in_ready_out),
      .out_valid_out(out_valid_out), .out_word_out(out_word_out),
      .out_ready_in(out_ready_in));
   ica_host_model u_host (.clk_in(clk_in), .reset_in(reset_in),
      .valid_in(out_valid_out), .word_in(out_word_out), .stall_in(stall),
      .ready_out(out_ready_in), .done_out(done), .crc_ok_out(crc_ok),
      .count_out(count), .words_out(words));
   // ================================================================
   // common tasks
   task automatic finish_test();
      $display("mismatches %0d samples_checked %0d", mismatches,
               samples_checked);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_in);
      bus_in.wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rdr(input logic [7:0] a);
      @(posedge clk_in);
      bus_in <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk_in);
      bus_in.rd <= 1'b0;
      @(negedge clk_in);
      rd = rdata_out;
   endtask
   // trigger, then n image words held until the appender takes each
   task automatic frame(input int n);
      @(posedge clk_in);
      trigger_in <= 1'b1;
      @(posedge clk_in);
      trigger_in <= 1'b0;
      out_lines_in <= 4'ha;
      for (int i = 0; i < n; i++) begin
         in_valid_in <= 1'b1;
         in_word_in  <= '{data: 32'h1234_0000 + i, last: i == n - 1};
         for (int t = 0; t <= 50; t++) begin
            if (t == 50) begin
               mismatches++;
               finish_test();
            end
            @(negedge clk_in);
            if (in_ready_out === 1'b1) break;
         end
         chk({31'h0, busy_out}, 32'h1);
         @(posedge clk_in);
      end
      in_valid_in <= 1'b0;
      for (int t = 0; t <= 200; t++) begin
         if (t == 200) begin
            mismatches++;
            finish_test();
         end
         @(negedge clk_in);
         if (done === 1'b1) break;
      end
      chk({31'h0, busy_out}, 32'h0);
   endtask
   // ================================================================
   // scenarios
   task automatic t_reset();
      rdr(ADDR_STATUS);
      chk(rd, 32'h0);
      rdr(8'h20);
      chk(rd, 32'h0);
      wr(ADDR_SELECT, {30'h0, SEL_LINES});
      wr(ADDR_ENABLE, 32'h1);
      rdr(ADDR_STATUS);
      chk(rd, 32'h0);
   endtask
   task automatic t_enable();
      wr(ADDR_CTRL, 32'h1);
      rdr(ADDR_CTRL);
      chk(rd, 32'h1);
      wr(ADDR_ENABLE, 32'h1);
      rdr(ADDR_ENABLE);
      chk(rd, 32'h1);
      wr(ADDR_SELECT, {30'h0, SEL_INDEX});
      wr(ADDR_ENABLE, 32'h1);
      rdr(ADDR_STATUS);
      chk(rd, 32'h1);
      @(posedge clk_in);
      seq_enabled_in <= 1'b1;
      wr(ADDR_ENABLE, 32'h1);
      wr(ADDR_SELECT, {30'h0, SEL_CHECKSUM});
      wr(ADDR_ENABLE, 32'h1);
      wr(ADDR_SELECT, 32'h3);
      wr(ADDR_ENABLE, 32'h1);
      rdr(ADDR_STATUS);
      chk(rd, 32'h7);
      rdr(ADDR_SELECT);
      chk(rd, 32'h3);
   endtask
   // all chunks under back-pressure; lines move after the trigger
   task automatic t_frame();
      logic [31:0] snap;
      snap = 32'h0;
      snap[IN_BASE +: NUM_IN_LINES] = 2'h2;
      snap[OUT_BASE +: NUM_OUT_LINES] = 4'h5;
      @(posedge clk_in);
      in_lines_in  <= 2'h2;
      out_lines_in <= 4'h5;
      seq_index_in <= 8'h5a;
      stall        <= 1'b1;
      repeat (4) @(posedge clk_in);
      frame(2);
      chk({28'h0, count}, 32'h5);
      chk(words[2], snap);
      chk(words[3], 32'h5a);
      chk({31'h0, crc_ok}, 32'h1);
      rdr(ADDR_LINES);
      chk(rd, snap);
      rdr(ADDR_CRC);
      chk(rd, {16'h0, words[4][15:0]});
   endtask
   task automatic t_off();
      @(posedge clk_in);
      stall <= 1'b0;
      wr(ADDR_SELECT, {30'h0, SEL_INDEX});
      wr(ADDR_ENABLE, 32'h0);
      rdr(ADDR_STATUS);
      chk(rd, 32'h5);
      wr(ADDR_CTRL, 32'h0);
      rdr(ADDR_STATUS);
      chk(rd, 32'h0);
      wr(ADDR_CTRL, 32'h1);
      frame(1);
      chk({28'h0, count}, 32'h1);
   endtask
   // ================================================================
   // clock, reset and main sequence
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   initial begin
      mismatches = 0;
      samples_checked = 0;
      reset_in = 1'b1;
      trigger_in = 1'b0;
      seq_enabled_in = 1'b0;
      seq_index_in = 8'h00;
      stall = 1'b0;
      in_valid_in = 1'b0;
      in_word_in = '0;
      bus_in = '0;
      in_lines_in = 2'h0;
      out_lines_in = 4'h0;
      repeat (2) @(posedge clk_in);
      reset_in <= 1'b0;
      t_reset();
      t_enable();
      t_frame();
      t_off();
      finish_test();
   end
endmodule
`default_nettype wire
